/* inc/dcc_defs.svh */
// offsets, field positions, reset values and codes of the comparator control block
// ****************************************************************
// Behaviour
// RULE1: comparator result bits are read-only
// RULE2: routed pins carry raw result, unsynchronised
// RULE3: direction bits still gate routed pins
// RULE4: bits 5:4 invert each comparator result
// RULE5: analog-input pins read back zero
// RULE6: any result change sets change flag
// RULE7: flag bit 6; software writes zero or one
// RULE8: interrupt needs three enables; flag still sets
// RULE9: mismatch keeps setting; register access ends it
// RULE10: change during read may miss flag
// RULE11: comparators and interrupt work in sleep
// RULE12: software selects mode 111 before sleep
// RULE13: wake leaves comparator control unchanged
// RULE14: reset gives mode 000, comparators off
// RULE15: two reference ranges, bit 5 selects
// RULE16: level/24 or 1/4 plus level/32
// RULE17: bit 4 selects reference supply source
// RULE18: reference powers down, works alone
// RULE19: software waits reference settling time
// RULE20: three-bit field selects eight modes
// RULE21: reference feeds comparators only in 110
// RULE22: reset clears reference control bits
// RULE23: result one when plus input higher
// RULE24: snapshot on access, compared every cycle
// ****************************************************************
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

`define DCC_ADDR_W        8
`define DCC_OFS_CMP_CTRL  8'h00
`define DCC_OFS_REF_CTRL  8'h04
`define DCC_OFS_IRQ_GLOB  8'h08
`define DCC_OFS_REQ_FLAGS 8'h0c
`define DCC_OFS_ENABLE    8'h10
`define DCC_OFS_PRIORITY  8'h14
`define DCC_OFS_PORT_DIR  8'h18
`define DCC_OFS_PORT_PINS 8'h1c

`define DCC_BIT_FLAG      6
`define DCC_BIT_PERIPHERAL_IRQ_ENABLE      6
`define DCC_BIT_GIE       7
`define DCC_CMP_WMASK     8'h3f
`define DCC_RST_BYTE      8'h00
`define DCC_RST_DIR       8'hff

`define DCC_MODE_RESET    3'b000
`define DCC_MODE_ROUTED   3'b011
`define DCC_MODE_REF_MUX  3'b110
`define DCC_MODE_OFF      3'b111

`define DCC_ANA_MASK_RST  8'h7e
`define DCC_ANA_MASK_RUN  8'h78
`define DCC_ANA_MASK_OFF  8'h00

`define DCC_PIN_OUT1      1
`define DCC_PIN_OUT2      2
`define DCC_PIN_REF       5

`define DCC_RATIO_W       6
`define DCC_DEN_HIGH      6'h18
`define DCC_DEN_LOW       6'h20
`define DCC_NUM_OFS_LOW   5'h08

`endif

/* inc/dcc_pkg.sv */
// types shared by the comparator control block
package dcc_pkg;

	// comparator control register layout
	typedef struct packed {
		logic       second_result;
		logic       first_result;
		logic       second_invert;
		logic       first_invert;
		logic       input_switch;
		logic [2:0] comparator_mode_field;
	} dcc_cmp_ctrl_t;

	// reference control register layout
	typedef struct packed {
		logic       reference_enable;
		logic       reference_output_enable;
		logic       reference_range;
		logic       reference_source_select;
		logic [3:0] reference_level;
	} dcc_ref_ctrl_t;

	// latched address phase
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} dcc_aphase_t;

	// ladder settings toward the analog side
	typedef struct packed {
		logic       powered;
		logic       source_external;
		logic       to_comparators;
		logic       to_pin;
		logic [5:0] numerator;
		logic [5:0] denominator;
	} dcc_ladder_t;

endpackage

/* design/dcc_top.sv */
// register file, change detect and pin routing of the dual comparator control
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defs.svh"

module dcc_top
(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	input  wire logic         first_raw,
	input  wire logic         second_raw,
	output logic [1:0]        comparator_power,
	output logic [2:0]        comparator_mode,
	output logic              input_switch,
	output dcc_pkg::dcc_ladder_t ladder,
	input  wire logic [7:0]   port_pins_in,
	output logic [7:0]        port_pins_out,
	output logic [7:0]        port_pins_oe,
	output logic [7:0]        analog_pin_mask,
	output logic              irq_request,
	output logic              wake_request
);

	// ****************************************************************
	// bus address phase
	// ****************************************************************
	dcc_pkg::dcc_aphase_t aph_reg;
	dcc_pkg::dcc_aphase_t aph_next;
	wire logic            take;
	wire logic [7:0]      a_addr;

	assign take = hsel & htrans[1] & hready;
	assign a_addr = haddr[7:0];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb
	begin
		aph_next.valid = take;
		aph_next.write = hwrite;
		aph_next.addr = a_addr;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			aph_reg <= '0;
		else
			aph_reg <= aph_next;
	end

	// data phase write strobes
	wire logic wr;
	wire logic wr_cmp;
	wire logic wr_ref;
	wire logic wr_glob;
	wire logic wr_flags;
	wire logic wr_en;
	wire logic wr_pri;
	wire logic wr_dir;
	wire logic wr_pins;
	wire logic [7:0] wbyte;

	assign wr = aph_reg.valid & aph_reg.write;
	assign wr_cmp = wr & (aph_reg.addr == `DCC_OFS_CMP_CTRL);
	assign wr_ref = wr & (aph_reg.addr == `DCC_OFS_REF_CTRL);
	assign wr_glob = wr & (aph_reg.addr == `DCC_OFS_IRQ_GLOB);
	assign wr_flags = wr & (aph_reg.addr == `DCC_OFS_REQ_FLAGS);
	assign wr_en = wr & (aph_reg.addr == `DCC_OFS_ENABLE);
	assign wr_pri = wr & (aph_reg.addr == `DCC_OFS_PRIORITY);
	assign wr_dir = wr & (aph_reg.addr == `DCC_OFS_PORT_DIR);
	assign wr_pins = wr & (aph_reg.addr == `DCC_OFS_PORT_PINS);
	assign wbyte = hwdata[7:0];

	// ****************************************************************
	// control registers
	// ****************************************************************
	logic [5:0]           cmp_cfg_reg;
	dcc_pkg::dcc_ref_ctrl_t ref_reg;
	logic [7:0]           glob_reg;
	logic                 flag_reg;
	logic                 flag_en_reg;
	logic                 flag_pri_reg;
	logic [7:0]           dir_reg;
	logic [7:0]           latch_reg;

	// only a hardware reset touches these; sleep and wake leave them alone
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cmp_cfg_reg <= 6'h00; // [RULE14]
			ref_reg <= '0; // [RULE22]
			glob_reg <= `DCC_RST_BYTE;
			flag_en_reg <= 1'b0;
			flag_pri_reg <= 1'b0;
			dir_reg <= `DCC_RST_DIR;
			latch_reg <= `DCC_RST_BYTE;
		end
		else
		begin
			if (wr_cmp)
				cmp_cfg_reg <= wbyte[5:0]; // [RULE1] [RULE13]
			if (wr_ref)
				ref_reg <= wbyte;
			if (wr_glob)
				glob_reg <= wbyte;
			if (wr_en)
				flag_en_reg <= wbyte[`DCC_BIT_FLAG];
			if (wr_pri)
				flag_pri_reg <= wbyte[`DCC_BIT_FLAG];
			if (wr_dir)
				dir_reg <= wbyte;
			if (wr_pins)
				latch_reg <= wbyte;
		end
	end

	// ****************************************************************
	// comparator results and mode decode
	// ****************************************************************
	wire logic [2:0] mode;
	wire logic       active;
	wire logic       first_res;
	wire logic       second_res;
	wire logic [1:0] live;

	assign mode = cmp_cfg_reg[2:0]; // [RULE20]
	assign active = (mode != `DCC_MODE_RESET) & (mode != `DCC_MODE_OFF); // [RULE14]
	// raw inputs are high when the plus input is above the minus input
	assign first_res = active & (first_raw ^ cmp_cfg_reg[4]); // [RULE4] [RULE23]
	assign second_res = active & (second_raw ^ cmp_cfg_reg[5]); // [RULE4] [RULE23]
	assign live = {second_res, first_res};

	assign comparator_power = {active, active}; // [RULE11]
	assign comparator_mode = mode;
	assign input_switch = cmp_cfg_reg[3];

	// ****************************************************************
	// change detect
	// ****************************************************************
	logic       copy_reg;
	logic [1:0] snap_reg;
	wire logic  touch;
	wire logic  mismatch;
	wire logic  flag_next;

	// a read or write of the comparator register is seen in its address phase
	assign touch = take & (a_addr == `DCC_OFS_CMP_CTRL);
	assign mismatch = copy_reg & (snap_reg != live); // [RULE24] [RULE6]

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			snap_reg <= 2'b00;
			copy_reg <= 1'b0;
		end
		else if (touch)
		begin
			snap_reg <= live; // [RULE24] [RULE9]
			copy_reg <= 1'b1;
		end
	end

	// set wins over a software clear in the same cycle; a change landing
	// in the snapshot cycle differs from the old snapshot and still sets the flag
	assign flag_next = mismatch | (wr_flags ? wbyte[`DCC_BIT_FLAG] : flag_reg); // [RULE7] [RULE9] [RULE10]

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flag_reg <= 1'b0;
		else
			flag_reg <= flag_next;
	end

	// flag sets regardless of enables; delivery needs all three
	assign irq_request = flag_reg & flag_en_reg & glob_reg[`DCC_BIT_PERIPHERAL_IRQ_ENABLE]
		& glob_reg[`DCC_BIT_GIE]; // [RULE8]
	// wake needs only the source enable so a sleeping core can resume
	assign wake_request = flag_reg & flag_en_reg; // [RULE11]

	// ****************************************************************
	// pins
	// ****************************************************************
	wire logic route;
	wire logic [7:0] ana_mask;

	assign route = (mode == `DCC_MODE_ROUTED);
	assign ana_mask = (mode == `DCC_MODE_OFF) ? `DCC_ANA_MASK_OFF
		: (mode == `DCC_MODE_RESET) ? `DCC_ANA_MASK_RST : `DCC_ANA_MASK_RUN;
	assign analog_pin_mask = ana_mask;

	// routed results bypass every flop: the pin follows the comparator directly
	always_comb
	begin
		port_pins_out = latch_reg;
		if (route)
		begin
			port_pins_out[`DCC_PIN_OUT1] = first_res; // [RULE2]
			port_pins_out[`DCC_PIN_OUT2] = second_res; // [RULE2]
		end
	end

	// direction bit low means driven, routed or not
	assign port_pins_oe = ~dir_reg; // [RULE3]

	// ****************************************************************
	// reference ladder
	// ****************************************************************
	wire logic [5:0] num_high;
	wire logic [5:0] num_low;

	assign num_high = {2'b00, ref_reg.reference_level};
	assign num_low = {1'b0, 5'(ref_reg.reference_level) + `DCC_NUM_OFS_LOW};

	always_comb
	begin
		ladder.powered = ref_reg.reference_enable; // [RULE18]
		ladder.source_external = ref_reg.reference_source_select; // [RULE17]
		ladder.to_comparators = ref_reg.reference_enable & (mode == `DCC_MODE_REF_MUX); // [RULE21]
		ladder.to_pin = ref_reg.reference_output_enable & dir_reg[`DCC_PIN_REF];
		// level/24 in the high range, (8+level)/32 in the low one
		ladder.numerator = ref_reg.reference_range ? num_high : num_low; // [RULE15] [RULE16]
		ladder.denominator = ref_reg.reference_range ? `DCC_DEN_HIGH : `DCC_DEN_LOW; // [RULE16]
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	logic [7:0] rbyte;

	always_comb
	begin
		case (a_addr)
			`DCC_OFS_CMP_CTRL:  rbyte = {live, cmp_cfg_reg}; // [RULE1]
			`DCC_OFS_REF_CTRL:  rbyte = ref_reg;
			`DCC_OFS_IRQ_GLOB:  rbyte = glob_reg;
			`DCC_OFS_REQ_FLAGS: rbyte = {1'b0, flag_reg, 6'h00};
			`DCC_OFS_ENABLE:    rbyte = {1'b0, flag_en_reg, 6'h00};
			`DCC_OFS_PRIORITY:  rbyte = {1'b0, flag_pri_reg, 6'h00};
			`DCC_OFS_PORT_DIR:  rbyte = dir_reg;
			`DCC_OFS_PORT_PINS: rbyte = port_pins_in & ~ana_mask; // [RULE5]
			default:            rbyte = 8'h00;
		endcase
	end

	// sampled at the address phase so data is a flop in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (take & ~hwrite)
			hrdata <= {24'h00_0000, rbyte};
	end

endmodule
`default_nettype wire

/* verif/dcc_monitor.sv */
// port assertions of the dual comparator control block
`timescale 1ns/100ps
`default_nettype none
module dcc_monitor
(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic                 hready,
	input  wire logic [1:0]           comparator_power,
	input  wire logic [2:0]           comparator_mode,
	input  wire logic [7:0]           analog_pin_mask,
	input  wire dcc_pkg::dcc_ladder_t ladder,
	input  wire logic                 irq_request,
	input  wire logic                 wake_request
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire run = comparator_mode != 3'h0 && comparator_mode != 3'h7;
	wire wr_addr = hsel && htrans[1] && hready && hwrite;
	sequence s_rel;
		$rose(hresetn);
	endsequence
	AST_IRQ: assert property (irq_request |-> wake_request)
		else $error("irq without enabled flag");
	AST_RST_CMP: assert property (s_rel |-> !run && comparator_power == 2'h0)
		else $error("comparators not off after reset");
	AST_RST_REF: assert property (s_rel |-> ladder == 16'h0220)
		else $error("ladder not cleared by reset");
	AST_RUN: assert property (run |-> comparator_power == 2'h3 && analog_pin_mask == 8'h78)
		else $error("running mode not powered");
	AST_OFF: assert property (comparator_mode == 3'h7 |-> comparator_power == 2'h0)
		else $error("off mode still powered");
	AST_REF: assert property (ladder.to_comparators |-> comparator_mode == 3'h6 && ladder.powered)
		else $error("reference fed outside mux mode");
	AST_LAD: assert property (ladder.denominator != 6'h18 |-> ladder.denominator == 6'h20
		&& ladder.numerator >= 6'h08 && ladder.numerator <= 6'h17) else $error("bad ladder ratio");
	AST_HOLD: assert property ($changed(comparator_mode) |-> $past(wr_addr, 2))
		else $error("mode changed without write");
endmodule
`default_nettype wire

/* verif/dcc_front_end.sv */
// model of the comparator front end and the port pads
`timescale 1ns/100ps
`default_nettype none
module dcc_front_end
(
	input  wire logic [1:0] plus_hi,
	input  wire logic [7:0] ext_lvl,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	output logic            first_raw,
	output logic            second_raw,
	output logic [7:0]      pin_in
);
	assign first_raw = plus_hi[0];
	assign second_raw = plus_hi[1];
	// released pads show the outside level, not the old latch
	assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

/* verif/dcc_top_tb_top.sv */
// self-checking bench of the dual comparator control block
`timescale 1ns/100ps
`default_nettype none
module dcc_top_tb_top;
	logic                 hclk = 1'b0;
	logic                 hresetn = 1'b0;
	logic [31:0]          haddr = 32'h0;
	logic [1:0]           htrans = 2'h0;
	logic                 hwrite = 1'b0;
	logic [31:0]          hwdata = 32'h0;
	logic                 hready;
	logic [31:0]          hrdata;
	logic [1:0]           plus_hi = 2'h0;
	logic [7:0]           ext_lvl = 8'h0;
	logic                 first_raw;
	logic                 second_raw;
	logic [1:0]           cpow;
	logic [7:0]           pin_in;
	logic [7:0]           pin_out;
	logic [7:0]           pin_oe;
	logic                 irq;
	logic                 wake;
	dcc_pkg::dcc_ladder_t ladder;
	int                   n_errors = 0;
	int                   check_count = 0;
	int                   cyc = 0;
	logic [31:0]          seed = 32'h7baf;
	logic [31:0]          q;
	logic [31:0]          r;
	logic [7:0]           c;
	logic [7:0]           d;
	logic [7:0]           o;

	dcc_top dcc_top_i (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready, .hreadyout(hready), .hresp(), .hrdata, .first_raw, .second_raw, .comparator_power(cpow),
		.comparator_mode(), .input_switch(), .ladder, .port_pins_in(pin_in), .port_pins_out(pin_out),
		.port_pins_oe(pin_oe), .analog_pin_mask(), .irq_request(irq), .wake_request(wake));
	dcc_front_end dcc_front_end_i (.plus_hi, .ext_lvl, .pin_out, .pin_oe, .first_raw, .second_raw, .pin_in);

	always #2.5 hclk = ~hclk;
	// a hung handshake ends the run here
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_errors++;
			stop_test();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [1:0] live(input logic [7:0] v);
		return (v[2:0] == 3'h0 || v[2:0] == 3'h7) ? 2'h0 : plus_hi ^ v[5:4];
	endfunction
	function automatic logic [7:0] amask(input logic [2:0] m);
		return m == 3'h0 ? 8'h7e : m == 3'h7 ? 8'h00 : 8'h78;
	endfunction

	// ****
	// bus master and comparisons
	// ****
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] x, output logic [31:0] y);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= x;
		do @(posedge hclk); while (hready !== 1'b1);
		y = hrdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0, q);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task automatic reset_chk();
		for (int a = 0; a < 36; a += 4)
			rdc(a[7:0], a == 24 ? 32'hff : a == 28 ? {24'h0, ext_lvl & 8'h81} : 32'h0);
		chk("ladder", 32'h0220, {16'h0, ladder});
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		r = rnd();
		ext_lvl <= r[7:0];
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		reset_chk();
		for (int m = 0; m < 8; m++)
		begin
			r = rnd();
			d = r[23:16];
			plus_hi <= r[9:8];
			c = {2'b11, r[5:3], m[2:0]};
			bus(8'h18, 1'b1, {24'h0, d}, q);
			bus(8'h00, 1'b1, {24'h0, c}, q);
			bus(8'h1c, 1'b1, r, q);
			rdc(8'h00, {24'h0, live(c), c[5:0]});
			o = r[7:0];
			if (m == 3)
				o[2:1] = live(c);
			o = (o & ~d) | (ext_lvl & d);
			rdc(8'h1c, {24'h0, o & ~amask(m[2:0])});
			chk("power", (m == 0 || m == 7) ? 2'h0 : 2'h3, cpow);
			if (m == 3)
			begin
				#1 plus_hi = ~plus_hi;
				#1 chk("route", live(c), pin_out[2:1]);
				@(posedge hclk);
			end
		end
		c = 8'h06;
		bus(8'h00, 1'b1, 32'h6, q);
		repeat (6)
		begin
			r = rnd();
			bus(8'h04, 1'b1, r, q);
			// let the ladder settle before anything leans on the results
			repeat (2) @(posedge hclk);
			rdc(8'h04, {24'h0, r[7:0]});
			chk("ladder", {r[7], r[4], r[7], r[6] & d[5], 6'(r[3:0]) + (r[5] ? 6'h0 : 6'h8),
				r[5] ? 6'h18 : 6'h20}, {16'h0, ladder});
		end
		bus(8'h10, 1'b1, 32'h40, q);
		bus(8'h08, 1'b1, 32'hc0, q);
		rdc(8'h00, {24'h0, live(c), c[5:0]});
		bus(8'h0c, 1'b1, 32'h0, q);
		rdc(8'h0c, 32'h0);
		plus_hi <= ~plus_hi;
		// flag flop loads on the first edge; look two edges later
		repeat (3) @(posedge hclk);
		chk("irq", 1'b1, irq);
		bus(8'h0c, 1'b1, 32'h0, q);
		rdc(8'h0c, 32'h40);
		rdc(8'h00, {24'h0, live(c), c[5:0]});
		bus(8'h0c, 1'b1, 32'h0, q);
		rdc(8'h0c, 32'h0);
		chk("irq", 1'b0, irq);
		bus(8'h0c, 1'b1, 32'h40, q);
		bus(8'h08, 1'b1, 32'h40, q);
		rdc(8'h00, {24'h0, live(c), c[5:0]});
		chk("irq", 1'b0, irq);
		chk("wake", 1'b1, wake);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		reset_chk();
		stop_test();
	end
endmodule

bind dcc_top dcc_monitor dcc_monitor_i (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .comparator_power,
	.comparator_mode, .analog_pin_mask, .ladder, .irq_request, .wake_request);
`default_nettype wire
